// File: common/adc_regs_pkg.sv
// constants, encodings and reset values for the limit registers and bus port
// ----------------------------------------------------------------------------
// Summary of operation
// - low limit word, read/write, resets 8000h
// - high limit word, read/write, resets 7FFFh
// - target never drives the serial clock low
// - address strap picks one of four addresses
// - setup word at pointer 1h, input_select field
// - select inputs 0..2 against input 3
// - single-ended results never go negative
// - limits compared as signed 16-bit values
// - low limit pointer 2h, high limit 3h
// - hi top set, lo top clear: ready pulses
// ----------------------------------------------------------------------------
package adc_regs_pkg;

  // --------------------------------------------------------------------------
  // register pointers
  // --------------------------------------------------------------------------
  localparam logic [1:0] PTR_CONV  = 2'h0;
  localparam logic [1:0] PTR_SETUP = 2'h1;
  localparam logic [1:0] PTR_LO    = 2'h2;
  localparam logic [1:0] PTR_HI    = 2'h3;

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [15:0] SETUP_RST = 16'h8583;
  localparam logic [15:0] LO_RST    = 16'h8000;
  localparam logic [15:0] HI_RST    = 16'h7fff;

  // --------------------------------------------------------------------------
  // setup word fields
  // --------------------------------------------------------------------------
  localparam int SEL_MSB  = 14;
  localparam int SEL_LSB  = 12;
  localparam int SE_BIT   = 14;
  localparam int MODE_BIT = 4;
  localparam int POL_BIT  = 3;
  localparam int QUE_MSB  = 1;
  localparam int QUE_LSB  = 0;
  localparam logic [1:0] QUE_OFF = 2'h3;

  // --------------------------------------------------------------------------
  // address strap codes
  // --------------------------------------------------------------------------
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VDD = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;
  localparam logic [1:0] STRAP_SCL = 2'h3;

  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_WAIT_NS   = 50000;
  localparam int POR_CYC = (POR_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // --------------------------------------------------------------------------
  // bus target states
  // --------------------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_ADDR  = 6'h02,
    S_ACK   = 6'h04,
    S_WRITE = 6'h08,
    S_READ  = 6'h10,
    S_MACK  = 6'h20
  } bus_state_t;

endpackage

// File: rtl/pin_filter.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module pin_filter #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // pins in, filtered out
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] q;
  } filt_t;

  filt_t st_r;
  filt_t st_nxt;

  // ff1 feeds only ff2; the agree test looks at ff2 and ff3
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ff1 = d;
    st_nxt.ff2 = st_r.ff1;
    st_nxt.ff3 = st_r.ff2;
    for (int i = 0; i < W; i++) begin
      if (st_r.ff2[i] == st_r.ff3[i]) begin
        st_nxt.q[i] = st_r.ff3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{ff1: INIT, ff2: INIT, ff3: INIT, q: INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;

endmodule

// File: rtl/adc_limit_regs_and_bus_port.sv
// two-wire bus target with pointer, setup and limit words and alert pin logic
`timescale 1ns/100ps
module adc_limit_regs_and_bus_port #(
  parameter int         POR_CYCLES = adc_regs_pkg::POR_CYC,
  // target addresses per strap; values are arbitrary
  parameter logic [6:0] ADDR_GND   = 7'h48,
  parameter logic [6:0] ADDR_VDD   = 7'h49,
  parameter logic [6:0] ADDR_SDA   = 7'h4a,
  parameter logic [6:0] ADDR_SCL   = 7'h4b
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // serial bus pins
  input  wire logic        scl_in,
  output      logic        scl_out,
  output      logic        scl_oe,
  input  wire logic        sda_in,
  output      logic        sda_out,
  output      logic        sda_oe,
  // address strap
  input  wire logic [1:0]  addr_strap,
  // converter side
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_code,
  output      logic [2:0]  input_select,
  // alert pin, open drain
  output      logic        alert_out,
  output      logic        alert_oe,
  // status
  output      logic        bus_ready
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    adc_regs_pkg::bus_state_t state;
    logic [2:0]  bit_cnt;
    logic [7:0]  shift;
    logic [1:0]  byte_idx;
    logic        rw;
    logic        ack_on;
    logic [1:0]  ptr;
    logic [7:0]  msb_hold;
    logic [15:0] tx;
    logic        sda_oe;
    logic        drv_low;
    logic        scl_hold;
    logic [15:0] setup;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] conv;
    logic        alert_act;
    logic        alert_oe;
    logic [15:0] por_cnt;
    logic        por_done;
    logic [6:0]  my_addr;
    logic        scl_prev;
    logic        sda_prev;
  } st_t;

  // edge history starts at the idle high level, so no false edge after reset
  localparam st_t ST_RST = '{
    state: adc_regs_pkg::S_IDLE, setup: adc_regs_pkg::SETUP_RST,
    lo: adc_regs_pkg::LO_RST, hi: adc_regs_pkg::HI_RST,
    scl_prev: 1'b1, sda_prev: 1'b1, default: '0};
  localparam logic [15:0] POR_LAST = 16'(POR_CYCLES - 1);

  st_t st_r;
  st_t st_nxt;

  logic       scl_f;
  logic       sda_f;
  logic [1:0] strap_f;

  pin_filter #(.W(4), .INIT(4'hf)) u_filt (
    .clk (clk),
    .rst (rst),
    .d   ({scl_in, sda_in, addr_strap}),
    .q   ({scl_f, sda_f, strap_f})
  );

  // --------------------------------------------------------------------------
  // bus events
  // --------------------------------------------------------------------------
  logic        rise;
  logic        fall;
  logic        start_c;
  logic        stop_c;
  logic [7:0]  new_byte;
  logic        commit;
  logic [15:0] rd_word;
  logic [15:0] cval;
  logic        gt;
  logic        lt;
  logic        rdy_mode;
  logic        pin_en;

  assign rise     = scl_f & ~st_r.scl_prev;
  assign fall     = ~scl_f & st_r.scl_prev;
  assign start_c  = scl_f & st_r.scl_prev & st_r.sda_prev & ~sda_f;
  assign stop_c   = scl_f & st_r.scl_prev & ~st_r.sda_prev & sda_f;
  assign new_byte = {st_r.shift[6:0], sda_f};
  assign commit   = (st_r.state == adc_regs_pkg::S_WRITE) & rise &
                    (st_r.bit_cnt == 3'h7) & (st_r.byte_idx == 2'h2);

  // diff selections 001..011 pass signed codes; 1xx are single-ended
  assign cval = (conv_code[15] & st_r.setup[adc_regs_pkg::SE_BIT]) ?
                16'h0000 : conv_code;
  assign gt   = $signed(cval) > $signed(st_r.hi);
  assign lt   = $signed(cval) < $signed(st_r.lo);
  assign rdy_mode = st_r.hi[15] & ~st_r.lo[15];

  always_comb begin
    unique case (st_r.ptr)
      adc_regs_pkg::PTR_CONV:  rd_word = st_r.conv;
      adc_regs_pkg::PTR_SETUP: rd_word = st_r.setup;
      adc_regs_pkg::PTR_LO:    rd_word = st_r.lo;
      adc_regs_pkg::PTR_HI:    rd_word = st_r.hi;
    endcase
  end

  function automatic logic [6:0] strap_addr(input logic [1:0] s);
    unique case (s)
      adc_regs_pkg::STRAP_GND: strap_addr = ADDR_GND;
      adc_regs_pkg::STRAP_VDD: strap_addr = ADDR_VDD;
      adc_regs_pkg::STRAP_SDA: strap_addr = ADDR_SDA;
      adc_regs_pkg::STRAP_SCL: strap_addr = ADDR_SCL;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.scl_prev = scl_f;
    st_nxt.sda_prev = sda_f;
    st_nxt.scl_hold = 1'b0;
    st_nxt.drv_low  = 1'b0;
    // strap is read once the power-on wait is over, so it has settled
    if (!st_r.por_done) begin
      st_nxt.por_cnt = st_r.por_cnt + 16'h0001;
      if (st_r.por_cnt == POR_LAST) begin
        st_nxt.por_done = 1'b1;
        st_nxt.my_addr  = strap_addr(strap_f);
      end
    end
    if (stop_c) begin
      st_nxt.state  = adc_regs_pkg::S_IDLE;
      st_nxt.sda_oe = 1'b0;
    end else if (start_c && st_r.por_done) begin
      st_nxt.state    = adc_regs_pkg::S_ADDR;
      st_nxt.bit_cnt  = 3'h0;
      st_nxt.byte_idx = 2'h0;
      st_nxt.ack_on   = 1'b0;
      st_nxt.sda_oe   = 1'b0;
    end else begin
      unique case (st_r.state)
        adc_regs_pkg::S_IDLE: begin
        end
        adc_regs_pkg::S_ADDR: begin
          if (rise) begin
            st_nxt.shift   = new_byte;
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
            if (st_r.bit_cnt == 3'h7) begin
              if (st_r.shift[6:0] == st_r.my_addr) begin
                st_nxt.state  = adc_regs_pkg::S_ACK;
                st_nxt.rw     = sda_f;
                st_nxt.ack_on = 1'b0;
              end else begin
                st_nxt.state = adc_regs_pkg::S_IDLE;
              end
            end
          end
        end
        adc_regs_pkg::S_ACK: begin
          if (fall && !st_r.ack_on) begin
            st_nxt.sda_oe = 1'b1;
            st_nxt.ack_on = 1'b1;
          end else if (fall) begin
            st_nxt.ack_on  = 1'b0;
            st_nxt.bit_cnt = 3'h0;
            if (st_r.rw) begin
              st_nxt.state = adc_regs_pkg::S_READ;
              if (st_r.byte_idx == 2'h0) begin
                st_nxt.tx = rd_word;
              end
              st_nxt.sda_oe = ~st_nxt.tx[15];
              if (st_r.byte_idx != 2'h3) begin
                st_nxt.byte_idx = st_r.byte_idx + 2'h1;
              end
            end else begin
              st_nxt.state  = adc_regs_pkg::S_WRITE;
              st_nxt.sda_oe = 1'b0;
            end
          end
        end
        adc_regs_pkg::S_WRITE: begin
          if (rise) begin
            st_nxt.shift   = new_byte;
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
            if (st_r.bit_cnt == 3'h7) begin
              st_nxt.state  = adc_regs_pkg::S_ACK;
              st_nxt.ack_on = 1'b0;
              if (st_r.byte_idx != 2'h3) begin
                st_nxt.byte_idx = st_r.byte_idx + 2'h1;
              end
              if (st_r.byte_idx == 2'h0) begin
                st_nxt.ptr = new_byte[1:0];
              end
              if (st_r.byte_idx == 2'h1) begin
                st_nxt.msb_hold = new_byte;
              end
            end
          end
          // words land only with their second byte, never half-written
          if (commit) begin
            unique case (st_r.ptr)
              adc_regs_pkg::PTR_CONV:  begin end
              adc_regs_pkg::PTR_SETUP: st_nxt.setup = {st_r.msb_hold, new_byte};
              adc_regs_pkg::PTR_LO:    st_nxt.lo = {st_r.msb_hold, new_byte};
              adc_regs_pkg::PTR_HI:    st_nxt.hi = {st_r.msb_hold, new_byte};
            endcase
          end
        end
        adc_regs_pkg::S_READ: begin
          if (fall) begin
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
            st_nxt.tx      = {st_r.tx[14:0], 1'b0};
            if (st_r.bit_cnt == 3'h7) begin
              st_nxt.sda_oe = 1'b0;
              st_nxt.state  = adc_regs_pkg::S_MACK;
            end else begin
              st_nxt.sda_oe = ~st_nxt.tx[15];
            end
          end
        end
        adc_regs_pkg::S_MACK: begin
          if (rise && !sda_f) begin
            st_nxt.state  = adc_regs_pkg::S_ACK;
            st_nxt.ack_on = 1'b1;
          end else if (rise) begin
            st_nxt.state = adc_regs_pkg::S_IDLE;
          end
        end
        default: st_nxt.state = adc_regs_pkg::S_IDLE;
      endcase
    end
    // comparator; limits in force are those at the conversion edge
    if (rdy_mode) begin
      st_nxt.alert_act = 1'b0;
    end
    if (conv_done) begin
      st_nxt.conv = cval;
      if (rdy_mode) begin
        st_nxt.alert_act = 1'b1;
      end else if (st_r.setup[adc_regs_pkg::MODE_BIT]) begin
        st_nxt.alert_act = gt | lt;
      end else if (gt) begin
        st_nxt.alert_act = 1'b1;
      end else if (lt) begin
        st_nxt.alert_act = 1'b0;
      end
    end
    pin_en = st_nxt.setup[adc_regs_pkg::QUE_MSB:adc_regs_pkg::QUE_LSB] !=
             adc_regs_pkg::QUE_OFF;
    // pin is pulled low when the active level is low
    st_nxt.alert_oe = pin_en & (st_nxt.setup[adc_regs_pkg::POL_BIT] ?
                      ~st_nxt.alert_act : st_nxt.alert_act);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign scl_out      = st_r.drv_low;
  assign scl_oe       = st_r.scl_hold;
  assign sda_out      = st_r.drv_low;
  assign sda_oe       = st_r.sda_oe;
  assign alert_out    = st_r.drv_low;
  assign alert_oe     = st_r.alert_oe;
  assign input_select =
    st_r.setup[adc_regs_pkg::SEL_MSB:adc_regs_pkg::SEL_LSB];
  assign bus_ready    = st_r.por_done;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence rdy_conv_s;
    rdy_mode && pin_en && conv_done;
  endsequence
  sequence rdy_pulse_s;
    st_r.alert_act ##1 !st_r.alert_act;
  endsequence

  lo_reset_a: assert property ($past(rst) |-> st_r.lo == 16'h8000)
    else $error("low limit reset value wrong");
  hi_reset_a: assert property ($past(rst) |-> st_r.hi == 16'h7fff)
    else $error("high limit reset value wrong");
  clock_free_a: assert property (!scl_oe)
    else $error("target drove the clock line");
  addr_miss_a: assert property (
    st_r.state == adc_regs_pkg::S_ADDR && rise
    && st_r.bit_cnt == 3'h7 && st_r.shift[6:0] != st_r.my_addr
    && !start_c && !stop_c |=> st_r.state == adc_regs_pkg::S_IDLE)
    else $error("foreign address was acknowledged");
  setup_reset_a: assert property (
    $past(rst) |-> st_r.setup == 16'h8583)
    else $error("setup word reset value wrong");
  diff_pass_a: assert property (conv_done
    && st_r.setup[14:12] inside {3'h1, 3'h2, 3'h3}
    |=> st_r.conv == $past(conv_code))
    else $error("shared reference result altered");
  se_clamp_a: assert property (conv_done && st_r.setup[14]
    && conv_code[15] |=> st_r.conv == 16'h0000)
    else $error("single-ended result went negative");
  win_high_a: assert property (conv_done && !rdy_mode && st_r.setup[4]
    && $signed(cval) > $signed(st_r.hi) |=> st_r.alert_act)
    else $error("signed high compare missed");
  lo_map_a: assert property (commit && st_r.ptr == 2'h2 && !start_c
    |=> st_r.lo == $past({st_r.msb_hold, new_byte}))
    else $error("pointer 2 did not reach low limit");
  rdy_pulse_a: assert property (rdy_conv_s |=> rdy_pulse_s)
    else $error("ready pulse shape wrong");
  whole_word_a: assert property (!$stable(st_r.lo) || !$stable(st_r.hi)
    |-> $past(commit))
    else $error("limit changed without a full word write");

endmodule

// File: testbench/i2c_host_model.sv
// two-wire bus host model: open-drain wires with pull-ups and byte tasks
`timescale 1ns/100ps
module i2c_host_model (
  // clock
  input  wire logic clk,
  // device drivers of the two wires
  input  wire logic scl_out,
  input  wire logic scl_oe,
  input  wire logic sda_out,
  input  wire logic sda_oe,
  input  wire logic bus_ready,
  // resolved wire levels
  output      logic scl,
  output      logic sda
);
  logic scl_low_r = 1'b0;
  logic sda_low_r = 1'b0;
  // cycles per bus phase; raise it to act as a slow host
  int   q         = 8;

  // pull-ups: a released wire reads high, never the last driven value
  assign scl = !(scl_low_r || (scl_oe && !scl_out));
  assign sda = !(sda_low_r || (sda_oe && !sda_out));

  task automatic gap();
    repeat (q) @(posedge clk);
    #1;
  endtask

  task automatic start();
    wait (bus_ready === 1'b1);
    gap();
    sda_low_r = 1'b1;
    gap();
    scl_low_r = 1'b1;
    gap();
  endtask

  task automatic stop();
    sda_low_r = 1'b1;
    gap();
    scl_low_r = 1'b0;
    gap();
    sda_low_r = 1'b0;
  endtask

  // data changes only while the clock wire is low
  task automatic bitx(input logic b, output logic r);
    sda_low_r = !b;
    gap();
    scl_low_r = 1'b0;
    gap();
    r = sda;
    scl_low_r = 1'b1;
    gap();
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(ack_in, ack_out);
  endtask

  // n is the count of data bytes after the pointer byte
  task automatic wr(input logic [6:0] a, input logic [1:0] p,
                    input logic [15:0] w, input int n, output logic ok);
    logic [7:0] rx;
    logic       k;
    start();
    xfer({a, 1'b0}, 1'b1, rx, k);
    ok = !k;
    xfer({6'h00, p}, 1'b1, rx, k);
    ok = ok && !k;
    if (n > 0) xfer(w[15:8], 1'b1, rx, k);
    if (n > 1) xfer(w[7:0], 1'b1, rx, k);
    stop();
  endtask

  task automatic rd(input logic [6:0] a, input logic [1:0] p,
                    output logic [15:0] w, output logic ok);
    logic k;
    wr(a, p, 16'h0000, 0, ok);
    start();
    xfer({a, 1'b1}, 1'b1, w[15:8], k);
    ok = ok && !k;
    xfer(8'hff, 1'b0, w[15:8], k);
    xfer(8'hff, 1'b1, w[7:0], k);
    stop();
  endtask
endmodule

// File: testbench/tb_top.sv
// self-checking bench for the limit registers and the bus target
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("BAD %0t: got %h expected %h", $time, got, exp); \
  end \
end
module tb_top;
  localparam int         POR     = 20;
  // target addresses per strap; values are arbitrary
  localparam logic [6:0] ADR [4] = '{7'h48, 7'h49, 7'h4a, 7'h4b};

  logic        clk;
  logic        rst;
  logic        scl;
  logic        sda;
  logic        scl_out;
  logic        scl_oe;
  logic        sda_out;
  logic        sda_oe;
  logic [1:0]  addr_strap;
  logic        conv_done;
  logic [15:0] conv_code;
  logic [2:0]  input_select;
  logic        alert_out;
  logic        alert_oe;
  logic        bus_ready;
  logic        scl_held = 1'b0;
  int          failures = 0;
  int          num_checks = 0;

  adc_limit_regs_and_bus_port #(
    .POR_CYCLES (POR),
    .ADDR_GND   (ADR[0]),
    .ADDR_VDD   (ADR[1]),
    .ADDR_SDA   (ADR[2]),
    .ADDR_SCL   (ADR[3])
  ) dut_u (
    .clk          (clk),
    .rst          (rst),
    .scl_in       (scl),
    .scl_out      (scl_out),
    .scl_oe       (scl_oe),
    .sda_in       (sda),
    .sda_out      (sda_out),
    .sda_oe       (sda_oe),
    .addr_strap   (addr_strap),
    .conv_done    (conv_done),
    .conv_code    (conv_code),
    .input_select (input_select),
    .alert_out    (alert_out),
    .alert_oe     (alert_oe),
    .bus_ready    (bus_ready)
  );

  i2c_host_model host_u (
    .clk       (clk),
    .scl_out   (scl_out),
    .scl_oe    (scl_oe),
    .sda_out   (sda_out),
    .sda_oe    (sda_oe),
    .bus_ready (bus_ready),
    .scl       (scl),
    .sda       (sda)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // sticky: any cycle out of reset with the clock wire driven
  always @(posedge clk) begin
    if (!rst && scl_oe !== 1'b0) scl_held <= 1'b1;
  end

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    test_done();
  end

  // --------------------------------------------------------------------------
  // access tasks
  // --------------------------------------------------------------------------
  task automatic do_reset(input int s);
    int n;
    rst = 1'b1;
    addr_strap = s[1:0];
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    `CHK(sda_oe, 1'b0)
    `CHK(alert_oe, 1'b0)
    `CHK(input_select, 3'b000)
    repeat (POR - 2) @(posedge clk);
    #1 `CHK(bus_ready, 1'b0)
    n = 0;
    while (bus_ready !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(bus_ready, 1'b1)
  endtask

  task automatic wreg(input logic [1:0] p, input logic [15:0] w);
    logic ok;
    host_u.wr(ADR[0], p, w, 2, ok);
    `CHK(ok, 1'b1)
  endtask

  task automatic rreg(input logic [1:0] p, input logic [15:0] e);
    logic        ok;
    logic [15:0] w;
    host_u.rd(ADR[0], p, w, ok);
    `CHK(ok, 1'b1)
    `CHK(w, e)
  endtask

  task automatic conv(input logic [15:0] c);
    @(posedge clk);
    #1 conv_done = 1'b1;
    conv_code = c;
    @(posedge clk);
    #1 conv_done = 1'b0;
  endtask

  // --------------------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------------------
  initial begin
    logic [15:0] sw;
    logic        ok;
    rst        = 1'b1;
    addr_strap = 2'h0;
    conv_done  = 1'b0;
    conv_code  = 16'h0000;
    for (int s = 3; s >= 0; s--) begin
      do_reset(s);
      host_u.wr(ADR[s], 2'h2, 16'h0000, 0, ok);
      `CHK(ok, 1'b1)
      host_u.wr(ADR[(s + 1) % 4], 2'h2, 16'h0000, 0, ok);
      `CHK(ok, 1'b0)
    end
    rreg(2'h1, 16'h8583);
    rreg(2'h2, 16'h8000);
    rreg(2'h3, 16'h7fff);
    wreg(2'h2, 16'h1234);
    wreg(2'h3, 16'hedcb);
    rreg(2'h2, 16'h1234);
    host_u.q = 20;
    rreg(2'h3, 16'hedcb);
    host_u.q = 8;
    // a word cut short after its first byte must leave the limit alone
    host_u.wr(ADR[0], 2'h2, 16'h5555, 1, ok);
    rreg(2'h2, 16'h1234);
    for (int i = 0; i < 8; i++) begin
      sw = {1'b1, 3'(i), 12'h583};
      wreg(2'h1, sw);
      `CHK(input_select, sw[14:12])
    end
    rreg(2'h1, sw);
    wreg(2'h1, 16'hc583);
    conv(16'h8001);
    rreg(2'h0, 16'h0000);
    conv(16'h7abc);
    rreg(2'h0, 16'h7abc);
    wreg(2'h1, 16'h0583);
    conv(16'h8001);
    rreg(2'h0, 16'h8001);
    // input 2 against input 3: signed codes pass untouched
    wreg(2'h1, 16'h3583);
    conv(16'h8001);
    rreg(2'h0, 16'h8001);
    wreg(2'h1, 16'h0580);
    wreg(2'h2, 16'hff00);
    wreg(2'h3, 16'h0100);
    conv(16'h0200);
    `CHK(alert_oe, 1'b1)
    conv(16'h0000);
    `CHK(alert_oe, 1'b1)
    // an unsigned compare would see this code as above the high limit
    conv(16'h8000);
    `CHK(alert_oe, 1'b0)
    wreg(2'h1, 16'h0590);
    conv(16'hfe00);
    `CHK(alert_oe, 1'b1)
    conv(16'h0000);
    `CHK(alert_oe, 1'b0)
    conv(16'h0200);
    wreg(2'h3, 16'h0300);
    `CHK(alert_oe, 1'b1)
    conv(16'h0200);
    `CHK(alert_oe, 1'b0)
    wreg(2'h3, 16'h8000);
    wreg(2'h2, 16'h0000);
    conv(16'h0000);
    `CHK(alert_oe, 1'b1)
    @(posedge clk);
    #1 `CHK(alert_oe, 1'b0)
    // active-high polarity: the pin is pulled low while idle in ready mode
    wreg(2'h1, 16'h0588);
    `CHK(alert_oe, 1'b1)
    conv(16'h0000);
    `CHK(alert_oe, 1'b0)
    @(posedge clk);
    #1 `CHK(alert_oe, 1'b1)
    `CHK(alert_out, 1'b0)
    `CHK(scl_held, 1'b0)
    test_done();
  end
endmodule
